// [pkg/dot_pkg.sv]
// Constants and types for the drive output terminal logic
package dot_pkg;
   localparam int CLK_PERIOD_NS = 100;
   // One delay unit is 0.1 s
   localparam int DELAY_UNIT_NS = 100_000_000;
   localparam int PULSE_UNIT_HZ = 10;
   localparam int NCO_HALF = 1_000_000_000 / (CLK_PERIOD_NS * 2 * PULSE_UNIT_HZ);
   localparam int NUM_TERMS = 4;

   localparam logic [7:0] REG_SRC_SEL = 8'h00;
   localparam logic [7:0] REG_OFFSET = 8'h04;
   localparam logic [7:0] REG_GAIN = 8'h08;
   localparam logic [7:0] REG_PULSE_FS = 8'h0c;
   localparam logic [7:0] REG_POLARITY = 8'h10;
   localparam logic [7:0] REG_DELAY0 = 8'h14;
   localparam logic [7:0] REG_DELAY3 = 8'h20;
   localparam logic [7:0] REG_SW_DELAY = 8'h24;
   localparam logic [7:0] REG_START_DELAY = 8'h28;
   localparam logic [7:0] REG_CTRL = 8'h2c;
   localparam logic [7:0] REG_STATUS = 8'h30;

   localparam int CTRL_CUR_MODE = 0;
   localparam int CTRL_PULSE_MODE = 1;
   localparam int CTRL_MOTOR_TWO = 2;
   localparam int CTRL_FN24_LSB = 4;

   localparam logic [3:0] RST_SRC_SEL = 4'h0;
   localparam logic [15:0] RST_OFFSET = 16'h0000;
   localparam logic [15:0] RST_GAIN = 16'h0064;
   localparam logic [15:0] RST_PULSE_FS = 16'h1388;
   localparam logic [3:0] RST_POLARITY = 4'h0;
   localparam logic [15:0] RST_DELAY = 16'h0000;
   localparam logic [15:0] RST_SW_DELAY = 16'h0001;
   localparam logic [15:0] RST_START_DELAY = 16'h0002;
   localparam logic [7:0] RST_CTRL = 8'h00;

   localparam logic signed [15:0] COEFF_MAX = 16'sh03e8;
   localparam logic [15:0] PULSE_FS_MIN = 16'h000a;
   localparam logic [15:0] PULSE_FS_MAX = 16'h1388;
   localparam logic [15:0] DELAY_MAX = 16'h8ca0;
   localparam logic [15:0] SEQ_DELAY_MIN = 16'h0001;
   localparam logic [15:0] SEQ_DELAY_MAX = 16'h0140;

   localparam int FULL_SCALE = 10000;
   localparam int GAIN_UNITY = 100;
   localparam int OFFSET_TO_OUT = 10;
   localparam logic [15:0] PULSE_IN_MIN = 16'h0064;
   localparam logic [15:0] PULSE_IN_SPAN = 16'h1324;
   localparam logic [15:0] AIN_FULL = 16'h2710;
   localparam logic [15:0] COMM_FULL = 16'h03e8;
   localparam logic [15:0] PULSE_OUT_MIN = 16'h0001;

   typedef enum logic [3:0] {
      SRC_RUN_FREQ = 4'h0,
      SRC_SET_FREQ = 4'h1,
      SRC_CURRENT = 4'h2,
      SRC_POWER = 4'h3,
      SRC_PULSE_IN = 4'h4,
      SRC_AIN_ONE = 4'h5,
      SRC_AIN_TWO = 4'h6,
      SRC_LENGTH = 4'h7,
      SRC_COUNT = 4'h8,
      SRC_COMM = 4'hc
   } dot_src_t;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_STOP = 2'b01,
      SEQ_SWITCH = 2'b10,
      SEQ_START = 2'b11
   } dot_seq_t;

   typedef struct packed {
      logic [15:0] run_freq;
      logic [15:0] set_freq;
      logic [15:0] max_freq;
      logic [15:0] out_current;
      logic [15:0] rated_current;
      logic [15:0] out_power;
      logic [15:0] rated_power;
      logic [15:0] pulse_in;
      logic [15:0] ain_one;
      logic [15:0] ain_two;
      logic [15:0] length;
      logic [15:0] max_length;
      logic [15:0] count;
      logic [15:0] max_count;
      logic [15:0] comm_set;
   } dot_sources_t;
endpackage

// [logic/dot_term_filter.sv]
// Persistence delay filter for one output terminal
`timescale 1ns/1ns
`default_nettype none
module dot_term_filter (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Time base and delay in 0.1 s units
   input wire logic tick,
   input wire logic [15:0] delay,
   // Internal state in, filtered state out
   input wire logic raw,
   output logic filt
);
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic next_filt;

   always_comb begin
      next_cnt = cnt;
      next_filt = filt;
      if (raw == filt) begin
         next_cnt = '0;
      // One tick past the delay, as the shared tick phase is free running
      end else if (delay == '0 || cnt > delay) begin
         next_filt = raw;
         next_cnt = '0;
      end else if (tick) begin
         next_cnt = cnt + 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         cnt <= '0;
         filt <= 1'b0;
      end else begin
         cnt <= next_cnt;
         filt <= next_filt;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   a_filt_delay_met: assert property (
      $changed(filt) |-> $past(delay) == '0 || $past(cnt) > $past(delay))
      else $error("terminal changed before its delay ran out");
   a_filt_restart: assert property (
      raw == filt |=> cnt == '0)
      else $error("delay timer kept counting after state returned");
   a_filt_zero_delay: assert property (
      delay == '0 && raw != filt |=> filt == $past(raw))
      else $error("zero delay did not pass state at once");
   c_filt_rise: cover property ($rose(filt));
endmodule
`default_nettype wire

// [logic/dot_output_terminals.sv]
// Drive output terminals: source scaling, pulse, relay/digital, switchover
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Select one of ten sources for output
// - Current and power span twice rated value
// - Actual output is gain times standard plus offset
// - Full offset equals full ten volt span
// - Offset and gain kept within allowed ranges
// - Standard output is source over full span
// - Pulse full scale frequency 0.1 to 50 kHz
// - Each terminal has own 0 to 3600 s delay
// - Changes shorter than delay never reach terminal
// - Polarity mask bit inverts terminal valid state
// - Wait switchover delay after stop, then contactor
// - Wait startup delay after contactor before start
// - Function 24 terminal drives motor contactor
// - Pulse frequency spans 0.01 kHz to full scale
module dot_output_terminals #(
   parameter int TICK_CYCLES = dot_pkg::DELAY_UNIT_NS / dot_pkg::CLK_PERIOD_NS
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Internal drive quantities
   input wire dot_pkg::dot_sources_t src,
   input wire logic [3:0] term_state,
   input wire logic drive_running,
   // Analog and pulse outputs
   output logic [13:0] analog_output,
   output logic analog_current_mode,
   output logic pulse_output_terminal,
   // Relay and digital terminals, high when closed to common
   output logic [3:0] term_closed,
   // Motor switchover
   output logic motor_contactor,
   output logic drive_stop_req,
   output logic drive_start_permit
);
   localparam int NT = dot_pkg::NUM_TERMS;
   localparam logic [13:0] FULL = 14'(dot_pkg::FULL_SCALE);

   logic [3:0] src_sel, next_src_sel;
   logic [15:0] offset, next_offset, gain, next_gain;
   logic [15:0] pulse_fs, next_pulse_fs;
   logic [NT-1:0] pol_mask, next_pol_mask;
   logic [15:0] dly [NT];
   logic [15:0] next_dly [NT];
   logic [15:0] sw_delay, next_sw_delay, start_delay, next_start_delay;
   logic [7:0] ctrl, next_ctrl;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr, do_write;
   logic [1:0] dly_idx;
   dot_pkg::dot_seq_t seq, next_seq;

   // Source value scaled to 0..FULL, clipped at full scale
   function automatic logic [13:0] norm(input logic [15:0] num,
                                        input logic [16:0] den);
      logic [31:0] q;
      q = '0;
      if (den != '0) begin
         q = ({16'h0000, num} * 32'(dot_pkg::FULL_SCALE)) / {15'h0000, den};
      end
      if (q > 32'(dot_pkg::FULL_SCALE)) begin
         q = 32'(dot_pkg::FULL_SCALE);
      end
      return q[13:0];
   endfunction

   function automatic logic [15:0] clamp_u(input logic [15:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
      logic [15:0] r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   function automatic logic [15:0] clamp_s(input logic [15:0] v);
      logic [15:0] r;
      r = v;
      if ($signed(v) > dot_pkg::COEFF_MAX) begin
         r = dot_pkg::COEFF_MAX;
      end else if ($signed(v) < -dot_pkg::COEFF_MAX) begin
         r = -dot_pkg::COEFF_MAX;
      end
      return r;
   endfunction

   // Register file; no wait states, pready and read data come from flops set in the setup phase
   assign do_write = psel && penable && pready && pwrite && !pslverr;
   assign dly_idx = 2'(paddr[5:2] - 4'h5);

   always_comb begin
      next_src_sel = src_sel;
      next_offset = offset;
      next_gain = gain;
      next_pulse_fs = pulse_fs;
      next_pol_mask = pol_mask;
      next_dly = dly;
      next_sw_delay = sw_delay;
      next_start_delay = start_delay;
      next_ctrl = ctrl;
      next_pready = psel && !penable;
      next_prdata = prdata;
      next_pslverr = 1'b0;
      if (psel && !penable) begin
         next_prdata = '0;
         unique case (paddr)
            dot_pkg::REG_SRC_SEL: next_prdata[3:0] = src_sel;
            dot_pkg::REG_OFFSET: next_prdata[15:0] = offset;
            dot_pkg::REG_GAIN: next_prdata[15:0] = gain;
            dot_pkg::REG_PULSE_FS: next_prdata[15:0] = pulse_fs;
            dot_pkg::REG_POLARITY: next_prdata[NT-1:0] = pol_mask;
            dot_pkg::REG_SW_DELAY: next_prdata[15:0] = sw_delay;
            dot_pkg::REG_START_DELAY: next_prdata[15:0] = start_delay;
            dot_pkg::REG_CTRL: next_prdata[7:0] = ctrl;
            dot_pkg::REG_STATUS: next_prdata[9:0] = {
               seq, drive_start_permit, drive_stop_req,
               motor_contactor, pulse_output_terminal, term_closed};
            default: begin
               if (paddr >= dot_pkg::REG_DELAY0 &&
                   paddr <= dot_pkg::REG_DELAY3 && paddr[1:0] == 2'h0) begin
                  next_prdata[15:0] = dly[dly_idx];
               end else begin
                  next_pslverr = 1'b1;
               end
            end
         endcase
      end
      if (do_write) begin
         unique case (paddr)
            dot_pkg::REG_SRC_SEL: begin
               // Unlisted codes are refused so the selector stays legal
               if (pwdata[3:0] <= 4'h8 || pwdata[3:0] == 4'hc) begin
                  next_src_sel = pwdata[3:0];
               end
            end
            dot_pkg::REG_OFFSET: next_offset = clamp_s(pwdata[15:0]);
            dot_pkg::REG_GAIN: next_gain = clamp_s(pwdata[15:0]);
            dot_pkg::REG_PULSE_FS: next_pulse_fs = clamp_u(pwdata[15:0],
               dot_pkg::PULSE_FS_MIN, dot_pkg::PULSE_FS_MAX);
            dot_pkg::REG_POLARITY: next_pol_mask = pwdata[NT-1:0];
            dot_pkg::REG_SW_DELAY: next_sw_delay = clamp_u(pwdata[15:0],
               dot_pkg::SEQ_DELAY_MIN, dot_pkg::SEQ_DELAY_MAX);
            dot_pkg::REG_START_DELAY: next_start_delay = clamp_u(
               pwdata[15:0], dot_pkg::SEQ_DELAY_MIN,
               dot_pkg::SEQ_DELAY_MAX);
            dot_pkg::REG_CTRL: next_ctrl = pwdata[7:0];
            dot_pkg::REG_STATUS: next_ctrl = ctrl;
            default: next_dly[dly_idx] = clamp_u(pwdata[15:0], 16'h0000,
               dot_pkg::DELAY_MAX);
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         src_sel <= dot_pkg::RST_SRC_SEL;
         offset <= dot_pkg::RST_OFFSET;
         gain <= dot_pkg::RST_GAIN;
         pulse_fs <= dot_pkg::RST_PULSE_FS;
         pol_mask <= dot_pkg::RST_POLARITY;
         for (int k = 0; k < NT; k++) begin
            dly[k] <= dot_pkg::RST_DELAY;
         end
         sw_delay <= dot_pkg::RST_SW_DELAY;
         start_delay <= dot_pkg::RST_START_DELAY;
         ctrl <= dot_pkg::RST_CTRL;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         src_sel <= next_src_sel;
         offset <= next_offset;
         gain <= next_gain;
         pulse_fs <= next_pulse_fs;
         pol_mask <= next_pol_mask;
         dly <= next_dly;
         sw_delay <= next_sw_delay;
         start_delay <= next_start_delay;
         ctrl <= next_ctrl;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // 0.1 s time base shared by all delays
   logic [31:0] tick_cnt, next_tick_cnt;
   logic tick, next_tick;

   always_comb begin
      next_tick = 1'b0;
      next_tick_cnt = tick_cnt + 32'h0000_0001;
      if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
         next_tick = 1'b1;
         next_tick_cnt = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         tick <= next_tick;
      end
   end

   // Analog path and pulse generator
   logic [13:0] std_out, y_sat;
   logic signed [31:0] y_full;
   logic [15:0] pin_rel, pulse_freq;
   logic [31:0] pf_wide;
   logic [19:0] nco, next_nco;
   logic next_pulse;

   assign pin_rel = (src.pulse_in > dot_pkg::PULSE_IN_MIN) ?
                    src.pulse_in - dot_pkg::PULSE_IN_MIN : 16'h0000;

   always_comb begin
      std_out = '0;
      unique case (dot_pkg::dot_src_t'(src_sel))
         dot_pkg::SRC_RUN_FREQ: std_out = norm(src.run_freq,
                                               {1'b0, src.max_freq});
         dot_pkg::SRC_SET_FREQ: std_out = norm(src.set_freq,
                                               {1'b0, src.max_freq});
         dot_pkg::SRC_CURRENT: std_out = norm(src.out_current,
                                              {src.rated_current, 1'b0});
         dot_pkg::SRC_POWER: std_out = norm(src.out_power,
                                            {src.rated_power, 1'b0});
         dot_pkg::SRC_PULSE_IN: std_out = norm(pin_rel,
                                               {1'b0, dot_pkg::PULSE_IN_SPAN});
         dot_pkg::SRC_AIN_ONE: std_out = norm(src.ain_one,
                                              {1'b0, dot_pkg::AIN_FULL});
         dot_pkg::SRC_AIN_TWO: std_out = norm(src.ain_two,
                                              {1'b0, dot_pkg::AIN_FULL});
         dot_pkg::SRC_LENGTH: std_out = norm(src.length,
                                             {1'b0, src.max_length});
         dot_pkg::SRC_COUNT: std_out = norm(src.count, {1'b0, src.max_count});
         dot_pkg::SRC_COMM: std_out = norm(src.comm_set,
                                           {1'b0, dot_pkg::COMM_FULL});
      endcase
      y_full = ($signed(gain) * $signed({18'h00000, std_out})) /
               dot_pkg::GAIN_UNITY +
               $signed(offset) * dot_pkg::OFFSET_TO_OUT;
      if (y_full < 0) begin
         y_sat = '0;
      end else if (y_full > dot_pkg::FULL_SCALE) begin
         y_sat = FULL;
      end else begin
         y_sat = y_full[13:0];
      end
      pf_wide = {16'h0000, pulse_fs - dot_pkg::PULSE_OUT_MIN} *
                {18'h00000, y_sat} / 32'(dot_pkg::FULL_SCALE);
      pulse_freq = dot_pkg::PULSE_OUT_MIN + pf_wide[15:0];
      next_nco = '0;
      next_pulse = 1'b0;
      if (ctrl[dot_pkg::CTRL_PULSE_MODE]) begin
         // Phase accumulator avoids a divider per period
         next_nco = nco + {4'h0, pulse_freq};
         next_pulse = pulse_output_terminal;
         if (next_nco >= 20'(dot_pkg::NCO_HALF)) begin
            next_nco = next_nco - 20'(dot_pkg::NCO_HALF);
            next_pulse = !pulse_output_terminal;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         analog_output <= '0;
         analog_current_mode <= 1'b0;
         nco <= '0;
         pulse_output_terminal <= 1'b0;
      end else begin
         analog_output <= y_sat;
         analog_current_mode <= ctrl[dot_pkg::CTRL_CUR_MODE];
         nco <= next_nco;
         pulse_output_terminal <= next_pulse;
      end
   end

   // Relay and digital terminals
   logic [NT-1:0] filtered;

   for (genvar i = 0; i < NT; i++) begin : g_term
      dot_term_filter u_filt (
         .core_clk(core_clk),
         .resetn(resetn),
         .tick(tick),
         .delay(dly[i]),
         .raw(ctrl[dot_pkg::CTRL_FN24_LSB + i] ? motor_contactor :
              term_state[i]),
         .filt(filtered[i])
      );
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         term_closed <= '0;
      end else begin
         term_closed <= filtered ^ pol_mask;
      end
   end

   // Motor switchover sequence
   logic [15:0] seq_cnt, next_seq_cnt;
   logic next_contactor, next_stop_req, next_permit, sw_due, start_due;

   // Strictly past the delay so a late tick never cuts the wait short
   assign sw_due = seq == dot_pkg::SEQ_SWITCH && seq_cnt > sw_delay;
   assign start_due = seq == dot_pkg::SEQ_START && seq_cnt > start_delay;

   always_comb begin
      next_seq = seq;
      next_seq_cnt = seq_cnt;
      next_contactor = motor_contactor;
      next_stop_req = drive_stop_req;
      next_permit = drive_start_permit;
      if (tick) begin
         next_seq_cnt = seq_cnt + 16'h0001;
      end
      unique case (seq)
         dot_pkg::SEQ_IDLE: begin
            next_seq_cnt = '0;
            if (ctrl[dot_pkg::CTRL_MOTOR_TWO] != motor_contactor) begin
               next_seq = dot_pkg::SEQ_STOP;
               next_stop_req = 1'b1;
               next_permit = 1'b0;
            end
         end
         dot_pkg::SEQ_STOP: begin
            next_seq_cnt = '0;
            if (!drive_running) begin
               next_seq = dot_pkg::SEQ_SWITCH;
            end
         end
         dot_pkg::SEQ_SWITCH: begin
            if (sw_due) begin
               next_contactor = ctrl[dot_pkg::CTRL_MOTOR_TWO];
               next_seq = dot_pkg::SEQ_START;
               next_seq_cnt = '0;
            end
         end
         dot_pkg::SEQ_START: begin
            if (start_due) begin
               next_seq = dot_pkg::SEQ_IDLE;
               next_stop_req = 1'b0;
               next_permit = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         seq <= dot_pkg::SEQ_IDLE;
         seq_cnt <= '0;
         motor_contactor <= 1'b0;
         drive_stop_req <= 1'b0;
         drive_start_permit <= 1'b1;
      end else begin
         seq <= next_seq;
         seq_cnt <= next_seq_cnt;
         motor_contactor <= next_contactor;
         drive_stop_req <= next_stop_req;
         drive_start_permit <= next_permit;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   a_run_freq_span: assert property (
      src_sel == 4'h0 && src.max_freq != '0 &&
      src.run_freq >= src.max_freq |-> std_out == FULL)
      else $error("running frequency at maximum not full scale");
   a_current_span: assert property (
      src_sel == 4'h2 && src.rated_current != '0 &&
      {1'b0, src.out_current} == {src.rated_current, 1'b0}
      |-> std_out == FULL)
      else $error("twice rated current not full scale");
   a_unity_gain: assert property (
      gain == 16'h0064 && offset == '0 |=> analog_output == $past(std_out))
      else $error("unity gain output differs from standard output");
   a_offset_full: assert property (
      gain == '0 && offset == 16'h03e8 |=> analog_output == FULL)
      else $error("full offset did not give full scale");
   a_coeff_range: assert property (
      $signed(gain) <= dot_pkg::COEFF_MAX &&
      $signed(gain) >= -dot_pkg::COEFF_MAX &&
      $signed(offset) <= dot_pkg::COEFF_MAX &&
      $signed(offset) >= -dot_pkg::COEFF_MAX)
      else $error("coefficient outside allowed range");
   a_pulse_range: assert property (
      pulse_freq >= dot_pkg::PULSE_OUT_MIN && pulse_freq <= pulse_fs &&
      pulse_fs <= dot_pkg::PULSE_FS_MAX)
      else $error("pulse frequency outside its span");
   a_out_saturate: assert property (
      y_full > dot_pkg::FULL_SCALE |=> analog_output == FULL)
      else $error("analog output did not saturate");
   a_polarity_mask: assert property (
      $stable(filtered) && $stable(pol_mask) |->
      term_closed == (filtered ^ pol_mask))
      else $error("terminal level disagrees with polarity");
   a_switch_wait: assert property (
      $changed(motor_contactor) |-> $past(sw_due) && !drive_start_permit)
      else $error("contactor changed outside switchover delay");
   a_start_wait: assert property (
      $rose(drive_start_permit) |-> $past(start_due) && !drive_stop_req)
      else $error("start permitted before startup delay");

   c_current_full: cover property (src_sel == 4'h2 && analog_output == FULL);
   c_contactor_on: cover property ($rose(motor_contactor));
   c_restart: cover property ($rose(drive_start_permit));
   c_pulse_edge: cover property ($rose(pulse_output_terminal));
endmodule
`default_nettype wire

// [test/dot_far_side.sv]
// Far-side model: drive power stage answering stop and start requests
`timescale 1ns/1ns
`default_nettype none
module dot_far_side #(
   parameter int LAG = 3
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Requests from the terminal logic
   input wire logic drive_stop_req,
   input wire logic drive_start_permit,
   // Drive state back to the terminal logic
   output logic drive_running
);
   int cnt;
   logic want;
   // Restart only once the permit is back
   assign want = !drive_stop_req && drive_start_permit;
   // Motor needs a few cycles to coast down or spin up
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         drive_running <= 1'b1;
         cnt <= 0;
      end else if (want == drive_running) begin
         cnt <= 0;
      end else if (cnt == LAG) begin
         drive_running <= want;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule
`default_nettype wire

// [test/drive_output_terminal_logic_tb.sv]
// Self-checking bench for the drive output terminals
`timescale 1ns/1ns
`default_nettype none
module drive_output_terminal_logic_tb;
   logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, rerr, drive_running, mc, sr, sp, pul, prev, cm;
   logic [3:0] term_state = 4'h0, tc;
   logic [13:0] ao;
   dot_pkg::dot_sources_t src = '0;
   logic [3:0] codes [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 12};
   int ex [10] = '{1000, 2000, 3000, 4000, 5000, 6000, 7000, 8000, 9000, 9500};
   int miscompares = 0, checks = 0, n, tm;
   always #50 core_clk = ~core_clk;
   dot_output_terminals #(.TICK_CYCLES(10)) u_dut (.core_clk(core_clk),
      .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src(src), .term_state(term_state),
      .drive_running(drive_running), .analog_output(ao),
      .analog_current_mode(cm), .pulse_output_terminal(pul),
      .term_closed(tc), .motor_contactor(mc), .drive_stop_req(sr),
      .drive_start_permit(sp));
   dot_far_side u_far (.core_clk(core_clk), .resetn(resetn),
      .drive_stop_req(sr), .drive_start_permit(sp),
      .drive_running(drive_running));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input int d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= 32'(d);
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic finish_test();
      $display("Checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      src <= '{16'h03e8, 16'h07d0, 16'h2710, 16'h003c, 16'h0064, 16'h0050,
         16'h0064, 16'h09f6, 16'h1770, 16'h1b58, 16'h0008, 16'h000a,
         16'h0009, 16'h000a, 16'h03b6};
      @(posedge core_clk);
      apb(0, dot_pkg::REG_GAIN, 0);
      chk(rd, 32'h64);
      apb(0, dot_pkg::REG_PULSE_FS, 0);
      chk(rd, 32'h1388);
      apb(0, dot_pkg::REG_START_DELAY, 0);
      chk(rd, 32'h2);
      apb(1, 8'h40, 5);
      chk(rerr, 1'b1);
      apb(1, dot_pkg::REG_SRC_SEL, 9);
      chk(rd, 32'h0);
      apb(0, dot_pkg::REG_SRC_SEL, 0);
      chk(rd, 32'h0);
      foreach (codes[i]) begin
         apb(1, dot_pkg::REG_SRC_SEL, codes[i]);
         repeat (3) @(posedge core_clk);
         chk(ao, ex[i]);
      end
      $display("Source routing done");
      apb(1, dot_pkg::REG_SRC_SEL, 0);
      apb(1, dot_pkg::REG_OFFSET, 800);
      apb(1, dot_pkg::REG_GAIN, -50);
      repeat (3) @(posedge core_clk);
      chk(ao, 7500);
      apb(1, dot_pkg::REG_GAIN, 2000);
      chk(rd, 32'h0000ffce);
      apb(0, dot_pkg::REG_GAIN, 0);
      chk(rd, 32'h3e8);
      repeat (3) @(posedge core_clk);
      chk(ao, 10000);
      apb(1, dot_pkg::REG_OFFSET, 0);
      apb(1, dot_pkg::REG_CTRL, 3);
      n = 0;
      prev = pul;
      repeat (2000) begin
         @(posedge core_clk);
         if (pul && !prev) n++;
         prev = pul;
      end
      chk(n >= 9 && n <= 11, 1);
      chk(cm, 1'b1);
      apb(1, dot_pkg::REG_CTRL, 0);
      $display("Scaling and pulse done");
      apb(1, dot_pkg::REG_DELAY0, 2);
      n = 0;
      for (int k = 0; k < 60; k++) begin
         term_state[0] <= (k < 8) || (k >= 10 && k < 18);
         @(posedge core_clk);
         n += tc[0];
      end
      chk(n, 0);
      term_state[0] <= 1'b1;
      n = 0;
      while (tc[0] !== 1'b1 && n < 60) begin
         @(posedge core_clk);
         n++;
      end
      chk(n >= 21 && n <= 33, 1);
      apb(1, dot_pkg::REG_POLARITY, 3);
      repeat (2) @(posedge core_clk);
      chk(tc[1:0], 2'b10);
      $display("Terminal filter done");
      apb(1, dot_pkg::REG_CTRL, 'h24);
      @(posedge core_clk);
      chk({mc, sr, sp}, 3'b010);
      n = 0;
      tm = 0;
      while (sp !== 1'b1 && n < 300) begin
         @(posedge core_clk);
         n++;
         if (mc === 1'b1 && tm == 0) begin
            tm = n;
            chk(drive_running, 1'b0);
         end
      end
      chk(tm >= 15 && tm <= 26, 1);
      chk(n - tm >= 21 && n - tm <= 31, 1);
      chk({mc, sr}, 2'b10);
      chk(tc[1], 1'b0);
      $display("Switchover done");
      finish_test();
   end
endmodule
`default_nettype wire
